// ===== verilog/gpr_consts.svh
// Constants of the pin function, pulse generator and scratch register group.
// Assumes inclusion by bare name from the register group module, the host model and the bench top.
`ifndef GPR_CONSTS_SVH
`define GPR_CONSTS_SVH

// Register addresses on the 7-bit serial register address.
`define GPR_ADDR_PIN_FN    7'h17
`define GPR_ADDR_DUTY      7'h18
`define GPR_ADDR_RATE      7'h1c
`define GPR_ADDR_HW3       7'h1d
`define GPR_ADDR_SCR_LO    7'h1e
`define GPR_ADDR_SCR_HI    7'h1f

// Power-on values.
`define GPR_POR_PIN_FN     3'h0
`define GPR_POR_DUTY       8'h00
`define GPR_POR_RATE       2'h0
`define GPR_POR_TSD        1'h0
`define GPR_POR_ILIM       2'h1
`define GPR_POR_SCR        8'h00

// Field positions.
`define GPR_PIN_FN_MSB     2
`define GPR_RATE_MSB       1
`define GPR_TSD_BIT        2
`define GPR_ILIM_MSB       1

// Pin function codes.
`define GPR_FN_TIMER_HS    3'h3
`define GPR_FN_OFF         3'h4
`define GPR_FN_WAKE        3'h5
`define GPR_FN_PWM_LS      3'h6
`define GPR_FN_PWM_HS      3'h7
`define GPR_FN_FAIL_MAX    3'h2

// Duty extremes and phase range of one period.
`define GPR_DUTY_OFF       8'h00
`define GPR_DUTY_ON        8'hff
`define GPR_PHASE_LAST     8'hfe
`define GPR_PWM_STEPS      255

// Clock and time figures.
`define GPR_CLK_HZ         20000000
`define GPR_CLK_NS         50
`define GPR_F0_HZ          100
`define GPR_F1_HZ          200
`define GPR_F2_HZ          325
`define GPR_F3_HZ          400
`define GPR_WAKE_FLT_NS    16000

`endif

// ===== verilog/gpr_pkg.sv
// Types of the pin function, pulse generator and scratch register group.
// Assumes nothing beyond the package itself.
package gpr_pkg;

  // Wake filter states, Gray coded around the loop.
  typedef enum logic [1:0] {
    GPR_FLT_LOW  = 2'h0,
    GPR_FLT_RISE = 2'h1,
    GPR_FLT_HIGH = 2'h3,
    GPR_FLT_FALL = 2'h2
  } gpr_flt_t;

  // Whole state of the register group.
  typedef struct packed {
    logic [2:0] pin_fn;
    logic [7:0] duty;
    logic [1:0] rate;
    logic       tsd;
    logic [1:0] ilim;
    logic [7:0] scr_lo;
    logic [7:0] scr_hi;
    logic       lock1_eff;
    logic [7:0] duty_act;
    logic [1:0] rate_act;
    logic [7:0] phase;
    logic [9:0] step_cnt;
    logic       sw;
    logic       pin_s1;
    logic       pin_s2;
    gpr_flt_t   flt;
    logic [8:0] flt_cnt;
    logic       wake;
    logic [7:0] rdata;
  } gpr_state_t;

endpackage : gpr_pkg

// ===== verilog/gpr_regs.sv
// Pin function, pulse width, thermal and current trim, and scratch registers.
// Assumes a serial front end on the same clock that decodes frames into
// single-cycle read and write strobes, and mode logic that gives reset
// pulses, lock levels and the present operating mode.
`timescale 1ns/10ps
`include "gpr_consts.svh"

module gpr_regs #(
  parameter int CLK_HZ = `GPR_CLK_HZ  // Core clock rate in Hz.
) (
  // Clock and power-on reset.
  input  wire logic       i_core_clk,
  input  wire logic       i_resetn,
  // Mode logic.
  input  wire logic       i_restart,
  input  wire logic       i_soft_reset,
  input  wire logic       i_normal_mode,
  input  wire logic       i_stop_mode,
  input  wire logic       i_failsafe_mode,
  input  wire logic       i_lock0,
  input  wire logic       i_lock1,
  input  wire logic       i_cs_rise,
  // Decoded register access.
  input  wire logic       i_wr,
  input  wire logic       i_rd,
  input  wire logic [6:0] i_addr,
  input  wire logic [7:0] i_wdata,
  output logic      [7:0] o_rdata,
  // Multi-purpose pin.
  input  wire logic       i_pin_level,
  output logic            o_fail_output_sel,
  output logic            o_timer_hs_sel,
  output logic            o_pin_off,
  output logic            o_wake_input_sel,
  output logic            o_wake_level,
  output logic            o_failsafe_wake_src,
  output logic            o_ls_switch_on,
  output logic            o_hs_switch_on,
  // Analog trims and scratch bytes.
  output logic            o_thermal_shutdown_level,
  output logic      [1:0] o_regulator_current_limit_trim,
  output logic      [7:0] o_scratch_low_byte,
  output logic      [7:0] o_scratch_high_byte
);

  ////////////////////////////////////////////////////////////////////////////
  // Timing counts.

  // Least filter time rounds up to whole cycles.
  localparam int CLK_NS    = 1000000000 / CLK_HZ;
  localparam int WAKE_CYC  = (`GPR_WAKE_FLT_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [8:0] WAKE_LAST = 9'(WAKE_CYC - 1);
  // Cycles per phase step; a period is 255 steps.
  localparam int STEP0 = CLK_HZ / (`GPR_F0_HZ * `GPR_PWM_STEPS);
  localparam int STEP1 = CLK_HZ / (`GPR_F1_HZ * `GPR_PWM_STEPS);
  localparam int STEP2 = CLK_HZ / (`GPR_F2_HZ * `GPR_PWM_STEPS);
  localparam int STEP3 = CLK_HZ / (`GPR_F3_HZ * `GPR_PWM_STEPS);

  // Last step count for a rate code.
  function automatic logic [9:0] step_last(input logic [1:0] rate);
    logic [9:0] v;
    v = 10'(STEP0 - 1);
    case (rate)
      2'h1:    v = 10'(STEP1 - 1);
      2'h2:    v = 10'(STEP2 - 1);
      2'h3:    v = 10'(STEP3 - 1);
      default: v = 10'(STEP0 - 1);
    endcase
    return v;
  endfunction : step_last

  ////////////////////////////////////////////////////////////////////////////
  // State.

  gpr_pkg::gpr_state_t st_r;   // Registered state.
  gpr_pkg::gpr_state_t st_nxt; // Next state.

  logic wr_pin_fn;  // Write to the pin function register.
  logic wr_duty;    // Write to the duty register.
  logic wr_rate;    // Write to the rate register.
  logic wr_hw3;     // Write to the thermal and current trim register.
  logic wr_scr_lo;  // Accepted write to the low scratch byte.
  logic wr_scr_hi;  // Accepted write to the high scratch byte.
  logic scr_rd_ok;  // Scratch bytes may be read in this mode.
  logic step_end;   // Last cycle of a phase step.
  logic period_end; // Last cycle of a period.
  logic pwm_fn;     // Pin runs from the pulse generator.

  // Decode writes; scratch writes need normal mode.
  always_comb begin
    wr_pin_fn  = i_wr && (i_addr == `GPR_ADDR_PIN_FN);
    wr_duty    = i_wr && (i_addr == `GPR_ADDR_DUTY);
    wr_rate    = i_wr && (i_addr == `GPR_ADDR_RATE);
    wr_hw3     = i_wr && (i_addr == `GPR_ADDR_HW3);
    wr_scr_lo  = i_wr && i_normal_mode && (i_addr == `GPR_ADDR_SCR_LO);
    wr_scr_hi  = i_wr && i_normal_mode && (i_addr == `GPR_ADDR_SCR_HI);
    scr_rd_ok  = i_normal_mode || i_stop_mode;
    step_end   = (st_r.step_cnt == step_last(st_r.rate_act));
    period_end = step_end && (st_r.phase == `GPR_PHASE_LAST);
    pwm_fn     = (st_r.pin_fn == `GPR_FN_PWM_LS) || (st_r.pin_fn == `GPR_FN_PWM_HS);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state.

  // All register, generator and filter updates are worked out here.
  always_comb begin
    st_nxt = st_r;

    // Configuration: restart first, then soft reset, then host writes.
    if (i_restart) begin
      // Restart keeps every setting as configured at that moment.
      st_nxt.pin_fn = st_r.pin_fn;
    end else if (i_soft_reset) begin
      // A locked pin code survives soft reset exactly like restart.
      if (!i_lock0) begin
        st_nxt.pin_fn = `GPR_POR_PIN_FN;
      end
      st_nxt.duty = `GPR_POR_DUTY;
      st_nxt.rate = `GPR_POR_RATE;
      // Trims survive soft reset once the level-1 lock holds.
      if (!st_r.lock1_eff) begin
        st_nxt.tsd  = `GPR_POR_TSD;
        st_nxt.ilim = `GPR_POR_ILIM;
      end
    end else begin
      // Only the low bits are stored, so upper bits drop silently.
      if (wr_pin_fn && !i_lock0) begin
        st_nxt.pin_fn = i_wdata[`GPR_PIN_FN_MSB:0];
      end
      if (wr_duty) begin
        st_nxt.duty = i_wdata;
      end
      if (wr_rate) begin
        st_nxt.rate = i_wdata[`GPR_RATE_MSB:0];
      end
      if (wr_hw3 && !st_r.lock1_eff) begin
        st_nxt.tsd  = i_wdata[`GPR_TSD_BIT];
        st_nxt.ilim = i_wdata[`GPR_ILIM_MSB:0];
      end
    end

    // Scratch bytes change by host writes alone, in every reset but power-on.
    if (wr_scr_lo) begin
      st_nxt.scr_lo = i_wdata;
    end
    if (wr_scr_hi) begin
      st_nxt.scr_hi = i_wdata;
    end

    // The lock takes hold at the frame end and then stays until power-up.
    if (i_cs_rise && i_lock1) begin
      st_nxt.lock1_eff = 1'b1;
    end

    // Pulse generator: steps, then the phase, then latching at period end.
    if (step_end) begin
      st_nxt.step_cnt = 10'h000;
      if (period_end) begin
        st_nxt.phase    = 8'h00;
        st_nxt.duty_act = st_r.duty;
        st_nxt.rate_act = st_r.rate;
      end else begin
        st_nxt.phase = st_r.phase + 8'h01;
      end
    end else begin
      st_nxt.step_cnt = st_r.step_cnt + 10'h001;
    end

    // Switch level from the latched duty against the phase count.
    if (st_r.duty_act == `GPR_DUTY_OFF) begin
      st_nxt.sw = 1'b0;
    end else if (st_r.duty_act == `GPR_DUTY_ON) begin
      st_nxt.sw = 1'b1;
    end else begin
      st_nxt.sw = (st_r.phase < st_r.duty_act);
    end

    // Two-stage synchroniser for the pin level.
    st_nxt.pin_s1 = i_pin_level;
    st_nxt.pin_s2 = st_r.pin_s1;

    // Static wake filter: a level must hold the whole filter time.
    if (st_r.pin_fn != `GPR_FN_WAKE) begin
      st_nxt.flt     = gpr_pkg::GPR_FLT_LOW;
      st_nxt.flt_cnt = 9'h000;
      st_nxt.wake    = 1'b0;
    end else begin
      case (st_r.flt)
        gpr_pkg::GPR_FLT_LOW: begin
          st_nxt.flt_cnt = 9'h000;
          if (st_r.pin_s2) begin
            st_nxt.flt = gpr_pkg::GPR_FLT_RISE;
          end
        end
        gpr_pkg::GPR_FLT_RISE: begin
          if (!st_r.pin_s2) begin
            st_nxt.flt = gpr_pkg::GPR_FLT_LOW; // A short pulse is dropped.
          end else if (st_r.flt_cnt == WAKE_LAST) begin
            st_nxt.flt     = gpr_pkg::GPR_FLT_HIGH;
            st_nxt.flt_cnt = 9'h000;
            st_nxt.wake    = 1'b1;
          end else begin
            st_nxt.flt_cnt = st_r.flt_cnt + 9'h001;
          end
        end
        gpr_pkg::GPR_FLT_HIGH: begin
          st_nxt.flt_cnt = 9'h000;
          if (!st_r.pin_s2) begin
            st_nxt.flt = gpr_pkg::GPR_FLT_FALL;
          end
        end
        gpr_pkg::GPR_FLT_FALL: begin
          if (st_r.pin_s2) begin
            st_nxt.flt = gpr_pkg::GPR_FLT_HIGH;
          end else if (st_r.flt_cnt == WAKE_LAST) begin
            st_nxt.flt     = gpr_pkg::GPR_FLT_LOW;
            st_nxt.flt_cnt = 9'h000;
            st_nxt.wake    = 1'b0;
          end else begin
            st_nxt.flt_cnt = st_r.flt_cnt + 9'h001;
          end
        end
        default: begin
          st_nxt.flt = gpr_pkg::GPR_FLT_LOW;
        end
      endcase
    end

    // Read data, reserved bits as zero, unmapped addresses as zero.
    if (i_rd) begin
      case (i_addr)
        `GPR_ADDR_PIN_FN: st_nxt.rdata = {5'h00, st_r.pin_fn};
        `GPR_ADDR_DUTY:   st_nxt.rdata = st_r.duty;
        `GPR_ADDR_RATE:   st_nxt.rdata = {6'h00, st_r.rate};
        `GPR_ADDR_HW3:    st_nxt.rdata = {5'h00, st_r.tsd, st_r.ilim};
        `GPR_ADDR_SCR_LO: st_nxt.rdata = scr_rd_ok ? st_r.scr_lo : 8'h00;
        `GPR_ADDR_SCR_HI: st_nxt.rdata = scr_rd_ok ? st_r.scr_hi : 8'h00;
        default:          st_nxt.rdata = 8'h00;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register.

  // Power-on reset loads every documented power-on value.
  always_ff @(posedge i_core_clk) begin
    if (!i_resetn) begin
      st_r           <= '0;
      st_r.pin_fn    <= `GPR_POR_PIN_FN;
      st_r.duty      <= `GPR_POR_DUTY;
      st_r.rate      <= `GPR_POR_RATE;
      st_r.tsd       <= `GPR_POR_TSD;
      st_r.ilim      <= `GPR_POR_ILIM;
      st_r.scr_lo    <= `GPR_POR_SCR;
      st_r.scr_hi    <= `GPR_POR_SCR;
      st_r.duty_act  <= `GPR_POR_DUTY;
      st_r.rate_act  <= `GPR_POR_RATE;
      st_r.flt       <= gpr_pkg::GPR_FLT_LOW;
    end else begin
      st_r <= st_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs.

  // Pin role decode; the host should load the duty before picking PWM.
  always_comb begin
    o_rdata                        = st_r.rdata;
    o_fail_output_sel              = (st_r.pin_fn <= `GPR_FN_FAIL_MAX);
    o_timer_hs_sel                 = (st_r.pin_fn == `GPR_FN_TIMER_HS);
    o_pin_off                      = (st_r.pin_fn == `GPR_FN_OFF);
    o_wake_input_sel               = (st_r.pin_fn == `GPR_FN_WAKE);
    o_wake_level                   = st_r.wake;
    o_failsafe_wake_src            = o_wake_input_sel && i_failsafe_mode;
    o_ls_switch_on = pwm_fn && (st_r.pin_fn == `GPR_FN_PWM_LS) && st_r.sw;
    o_hs_switch_on = pwm_fn && (st_r.pin_fn == `GPR_FN_PWM_HS) && st_r.sw;
    o_thermal_shutdown_level       = st_r.tsd;
    o_regulator_current_limit_trim = st_r.ilim;
    o_scratch_low_byte             = st_r.scr_lo;
    o_scratch_high_byte            = st_r.scr_hi;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_resetn);

  // A low scratch byte write outside normal mode.
  sequence s_scr_blocked;
    i_wr && !i_normal_mode && (i_addr == `GPR_ADDR_SCR_LO);
  endsequence

  // A reset pulse other than power-on.
  sequence s_any_reset;
    i_restart || i_soft_reset;
  endsequence

  AST_RSVD_ZERO: assert property (
    i_rd && (i_addr == `GPR_ADDR_PIN_FN) |=> o_rdata[7:3] == 5'h00)
    else $error("Reserved pin function bits read nonzero.");
  AST_LOCK0_HOLD: assert property (
    wr_pin_fn && i_lock0 && !i_restart |=> $stable(st_r.pin_fn))
    else $error("Locked pin code changed by a write.");
  AST_DUTY_LATCH: assert property (
    !period_end |=> $stable(st_r.duty_act))
    else $error("Duty applied inside a period.");
  AST_RATE_LATCH: assert property (
    !period_end |=> $stable(st_r.rate_act))
    else $error("Rate applied inside a period.");
  AST_DUTY_OFF: assert property (
    st_r.duty_act == `GPR_DUTY_OFF ##1 st_r.duty_act == `GPR_DUTY_OFF |-> !st_r.sw)
    else $error("Switch on with zero duty.");
  AST_DUTY_FULL: assert property (
    st_r.duty_act == `GPR_DUTY_ON |=> st_r.sw)
    else $error("Switch off with full duty.");
  AST_SCR_KEEP: assert property (
    s_any_reset and !i_wr |=> $stable(st_r.scr_lo) && $stable(st_r.scr_hi))
    else $error("Scratch bytes lost in a reset.");
  AST_SCR_RO: assert property (
    s_scr_blocked |=> $stable(st_r.scr_lo))
    else $error("Scratch written outside normal mode.");
  AST_WAKE_FILTER: assert property (
    $rose(st_r.wake) |-> $past(st_r.flt_cnt) == WAKE_LAST && $past(st_r.pin_s2))
    else $error("Wake level rose before the filter time.");
  AST_LOCK1_STICKY: assert property (
    st_r.lock1_eff |=> st_r.lock1_eff && $stable(st_r.ilim) && $stable(st_r.tsd))
    else $error("Level-1 lock released or trims changed.");

endmodule : gpr_regs

// ===== bench/gpr_host_model.sv
////////////////////////////////////////////////////////////////////////////////
// Host microcontroller model: register writes, reads and frame ends.
// Assumes the bench clock; all requests change just after a falling edge.
////////////////////////////////////////////////////////////////////////////////
`timescale 1ns/10ps
`include "gpr_consts.svh"
module gpr_host_model (
  // Clock.
  input  wire logic       i_core_clk,
  // Register access towards the device.
  output logic            o_wr,
  output logic            o_rd,
  output logic      [6:0] o_addr,
  output logic      [7:0] o_wdata,
  output logic            o_cs_rise,
  // Read data from the device.
  input  wire logic [7:0] i_rdata
);
  // Idle bus at time zero.
  initial begin
    o_wr      = 1'b0;
    o_rd      = 1'b0;
    o_addr    = 7'h00;
    o_wdata   = 8'h00;
    o_cs_rise = 1'b0;
  end

  // One write; data is inverted afterwards so a stale value is never reused.
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(negedge i_core_clk);
    o_addr  = a;
    o_wdata = d;
    o_wr    = 1'b1;
    @(negedge i_core_clk);
    o_wr    = 1'b0;
    o_wdata = ~d;
  endtask : wr

  // One read; data is valid the cycle after the strobe edge.
  task automatic rd(input logic [6:0] a, output logic [7:0] d);
    @(negedge i_core_clk);
    o_addr = a;
    o_rd   = 1'b1;
    @(negedge i_core_clk);
    o_rd   = 1'b0;
    d      = i_rdata;
  endtask : rd

  // End of a frame: chip-select returns high for one cycle.
  task automatic frame_end();
    @(negedge i_core_clk);
    o_cs_rise = 1'b1;
    @(negedge i_core_clk);
    o_cs_rise = 1'b0;
  endtask : frame_end

  // Pulse output setup: the duty goes in before the switch function.
  task automatic pwm_setup(input logic [7:0] duty, input logic [2:0] code);
    wr(`GPR_ADDR_DUTY, duty);
    wr(`GPR_ADDR_PIN_FN, {5'h00, code});
  endtask : pwm_setup
endmodule : gpr_host_model

// ===== bench/gpr_regs_tb_top.sv
////////////////////////////////////////////////////////////////////////////////
// Self-checking bench of the register group, driven through the host model.
// Assumes the design and host model are compiled first; inputs change at negedge.
////////////////////////////////////////////////////////////////////////////////
`timescale 1ns/10ps
`include "gpr_consts.svh"
module gpr_regs_tb_top;
  // Slow core rate gives whole step counts of 8 and 2 at 100 and 400 Hz.
  localparam int CLK_HZ = 204000;
  logic       i_core_clk, i_resetn;
  logic       restart, soft_rst, normal, stop, fsafe, lock0, lock1, pin;
  logic       wr, rd, cs_rise, fo, tmr, off, wsel, wlvl, fwsrc, ls, hs, tsd;
  logic [6:0] addr;
  logic [7:0] wdata, rdata, scr_lo, scr_hi, v;
  logic [1:0] trim;
  int         n_fail, total_checks;

  gpr_regs #(.CLK_HZ(CLK_HZ)) dut (
    .i_core_clk(i_core_clk), .i_resetn(i_resetn), .i_restart(restart),
    .i_soft_reset(soft_rst), .i_normal_mode(normal), .i_stop_mode(stop),
    .i_failsafe_mode(fsafe), .i_lock0(lock0), .i_lock1(lock1), .i_cs_rise(cs_rise),
    .i_wr(wr), .i_rd(rd), .i_addr(addr), .i_wdata(wdata), .o_rdata(rdata),
    .i_pin_level(pin), .o_fail_output_sel(fo), .o_timer_hs_sel(tmr), .o_pin_off(off),
    .o_wake_input_sel(wsel), .o_wake_level(wlvl), .o_failsafe_wake_src(fwsrc),
    .o_ls_switch_on(ls), .o_hs_switch_on(hs), .o_thermal_shutdown_level(tsd),
    .o_regulator_current_limit_trim(trim), .o_scratch_low_byte(scr_lo),
    .o_scratch_high_byte(scr_hi));
  gpr_host_model u_host (
    .i_core_clk(i_core_clk), .o_wr(wr), .o_rd(rd), .o_addr(addr), .o_wdata(wdata),
    .o_cs_rise(cs_rise), .i_rdata(rdata));

  ////////////////////////////////////////////////////////////////////////////////
  // Shared checks.
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic rc(input logic [6:0] a, input logic [7:0] exp, input string nm);
    u_host.rd(a, v);
    chk(nm, {8'h00, exp}, {8'h00, v});
  endtask : rc
  task automatic pulse(ref logic s);
    @(negedge i_core_clk);
    s = 1'b1;
    @(negedge i_core_clk);
    s = 1'b0;
  endtask : pulse
  // Bounded wait for a switch level; a timeout shows as a mismatch.
  task automatic wait_sw(input logic lvl);
    int k;
    k = 0;
    while (ls !== lvl && k < 3000) begin
      @(negedge i_core_clk);
      k++;
    end
    chk("sw_wait", {15'h0, lvl}, {15'h0, ls});
  endtask : wait_sw
  task automatic count_on(input int n, input int exp, input string nm);
    int on;
    on = 0;
    repeat (n) begin
      if (ls === 1'b1) on++;
      @(negedge i_core_clk);
    end
    chk(nm, exp[15:0], on[15:0]);
  endtask : count_on
  task automatic end_of_test();
    $display("Checks %0d, mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : end_of_test

  ////////////////////////////////////////////////////////////////////////////////
  // Scenarios.
  task automatic t_fields();
    rc(`GPR_ADDR_HW3, 8'h01, "hw3_por");
    rc(`GPR_ADDR_SCR_HI, 8'h00, "scr_por");
    for (int c = 0; c < 8; c++) begin
      u_host.wr(`GPR_ADDR_PIN_FN, {5'h1f, c[2:0]});
      rc(`GPR_ADDR_PIN_FN, {5'h00, c[2:0]}, "pin_fn");
      chk("sel", {12'h0, c < 3, c == 3, c == 4, c == 5}, {12'h0, fo, tmr, off, wsel});
    end
    u_host.wr(`GPR_ADDR_RATE, 8'hff);
    rc(`GPR_ADDR_RATE, 8'h03, "rate");
    u_host.wr(`GPR_ADDR_HW3, 8'hff);
    rc(`GPR_ADDR_HW3, 8'h07, "hw3");
    chk("tsd_trim", 16'h0007, {13'h0, tsd, trim});
    u_host.wr(7'h20, 8'hff);
    rc(7'h20, 8'h00, "unmapped");
    $display("Test fields done");
  endtask : t_fields

  task automatic t_lock0();
    u_host.wr(`GPR_ADDR_PIN_FN, 8'h05);
    lock0 = 1'b1;
    u_host.wr(`GPR_ADDR_PIN_FN, 8'h06);
    rc(`GPR_ADDR_PIN_FN, 8'h05, "pin_locked");
    pulse(soft_rst);
    rc(`GPR_ADDR_PIN_FN, 8'h05, "pin_soft_locked");
    lock0 = 1'b0;
    u_host.wr(`GPR_ADDR_DUTY, 8'h33);
    pulse(restart);
    rc(`GPR_ADDR_PIN_FN, 8'h05, "pin_restart");
    pulse(soft_rst);
    rc(`GPR_ADDR_PIN_FN, 8'h00, "pin_soft");
    rc(`GPR_ADDR_DUTY, 8'h00, "duty_soft");
    rc(`GPR_ADDR_RATE, 8'h00, "rate_soft");
    rc(`GPR_ADDR_HW3, 8'h01, "hw3_soft");
    $display("Test lock0 done");
  endtask : t_lock0

  task automatic t_scratch();
    u_host.wr(`GPR_ADDR_SCR_LO, 8'h5a);
    u_host.wr(`GPR_ADDR_SCR_HI, 8'ha5);
    pulse(soft_rst);
    pulse(restart);
    rc(`GPR_ADDR_SCR_LO, 8'h5a, "scr_lo_kept");
    rc(`GPR_ADDR_SCR_HI, 8'ha5, "scr_hi_kept");
    normal = 1'b0;
    stop   = 1'b1;
    u_host.wr(`GPR_ADDR_SCR_HI, 8'h11);
    rc(`GPR_ADDR_SCR_HI, 8'ha5, "scr_stop");
    stop  = 1'b0;
    fsafe = 1'b1;
    rc(`GPR_ADDR_SCR_LO, 8'h00, "scr_fs_read");
    chk("scr_out", 16'ha55a, {scr_hi, scr_lo});
    fsafe  = 1'b0;
    normal = 1'b1;
    $display("Test scratch done");
  endtask : t_scratch

  task automatic t_lock1();
    lock1 = 1'b1;
    u_host.wr(`GPR_ADDR_HW3, 8'h04);
    rc(`GPR_ADDR_HW3, 8'h04, "hw3_pre_lock");
    u_host.frame_end();
    lock1 = 1'b0;
    u_host.frame_end();
    u_host.wr(`GPR_ADDR_HW3, 8'h02);
    rc(`GPR_ADDR_HW3, 8'h04, "hw3_locked");
    pulse(soft_rst);
    rc(`GPR_ADDR_HW3, 8'h04, "hw3_soft_locked");
    u_host.wr(`GPR_ADDR_SCR_LO, 8'h77);
    i_resetn = 1'b0;
    repeat (2) @(negedge i_core_clk);
    i_resetn = 1'b1;
    rc(`GPR_ADDR_HW3, 8'h01, "hw3_after_por");
    rc(`GPR_ADDR_SCR_LO, 8'h00, "scr_after_por");
    $display("Test lock1 done");
  endtask : t_lock1

  task automatic t_wake();
    u_host.wr(`GPR_ADDR_PIN_FN, 8'h05);
    fsafe = 1'b1;
    @(negedge i_core_clk);
    chk("fs_wake_src", 16'h1, {15'h0, fwsrc});
    pin = 1'b1;
    @(negedge i_core_clk);
    pin = 1'b0;
    repeat (20) @(negedge i_core_clk);
    chk("wake_glitch", 16'h0, {15'h0, wlvl});
    pin = 1'b1;
    repeat (5) @(negedge i_core_clk);
    chk("wake_early", 16'h0, {15'h0, wlvl});
    repeat (55) @(negedge i_core_clk);
    chk("wake_high", 16'h1, {15'h0, wlvl});
    pin = 1'b0;
    @(negedge i_core_clk);
    pin = 1'b1;
    repeat (20) @(negedge i_core_clk);
    chk("wake_hold", 16'h1, {15'h0, wlvl});
    pin = 1'b0;
    repeat (60) @(negedge i_core_clk);
    chk("wake_low", 16'h0, {15'h0, wlvl});
    // Fail-safe stays on, so only the pin code can clear the wake source.
    u_host.wr(`GPR_ADDR_PIN_FN, 8'h00);
    chk("fs_wake_off", 16'h0, {15'h0, fwsrc});
    fsafe = 1'b0;
    $display("Test wake done");
  endtask : t_wake

  // Period is 255 steps: 510 cycles at code 11, 2040 at code 00.
  task automatic t_pwm();
    u_host.wr(`GPR_ADDR_RATE, 8'h03);
    u_host.pwm_setup(8'h80, 3'h6);
    wait_sw(1'b1);
    chk("hs_off", 16'h0, {15'h0, hs});
    fork
      count_on(510, 256, "on_old_duty");
      begin
        repeat (2) @(negedge i_core_clk);
        u_host.wr(`GPR_ADDR_DUTY, 8'h00);
        u_host.wr(`GPR_ADDR_RATE, 8'h00);
      end
    join
    count_on(2040, 0, "on_zero");
    u_host.wr(`GPR_ADDR_DUTY, 8'hff);
    repeat (2100) @(negedge i_core_clk);
    count_on(510, 510, "on_full");
    // Full duty keeps the level up, so the high-side code must show it at once.
    u_host.wr(`GPR_ADDR_PIN_FN, 8'h07);
    chk("hs_pwm", 16'h0002, {14'h0, hs, ls});
    u_host.wr(`GPR_ADDR_PIN_FN, 8'h06);
    u_host.wr(`GPR_ADDR_DUTY, 8'h80);
    wait_sw(1'b0);
    wait_sw(1'b1);
    count_on(2040, 1024, "on_100hz");
    // Rate code 01 gives 4-cycle steps here: a 1020-cycle period, 512 cycles of it on.
    u_host.wr(`GPR_ADDR_RATE, 8'h01);
    wait_sw(1'b0);
    wait_sw(1'b1);
    count_on(1020, 512, "on_200hz");
    $display("Test pwm done");
  endtask : t_pwm

  ////////////////////////////////////////////////////////////////////////////////
  // Clock, main sequence and watchdog.
  initial begin
    i_core_clk = 1'b0;
    forever #25 i_core_clk = ~i_core_clk;
  end
  initial begin
    {i_resetn, restart, soft_rst, stop, fsafe, lock0, lock1, pin} = 8'h00;
    normal       = 1'b1;
    n_fail       = 0;
    total_checks = 0;
    repeat (6) @(negedge i_core_clk);
    i_resetn = 1'b1;
    t_fields();
    t_lock0();
    t_scratch();
    t_lock1();
    t_wake();
    t_pwm();
    end_of_test();
  end
  // The run needs about 16000 cycles; the limit leaves ample margin.
  initial begin
    repeat (40000) @(posedge i_core_clk);
    n_fail++;
    $display("[ERR] watchdog expected done seen hang");
    end_of_test();
  end
endmodule : gpr_regs_tb_top
